// ===== design/input_dispatch.sv
// Purpose: Decode terminal functions and drive run/stop sequencing signals.
// Assumes: Terminal levels are debounced and synchronous to pclk.
// Notes: Summary of operation follows.
// Summary of operation
// - Terminals with codes 1-4 form a binary multi-step speed number.
// - Reset terminal clears latched fault once its cause is gone.
// - Function-6 jog only honoured with external terminal run source.
// - Jog output starts only after the drive is fully stopped.
// - Jog accepts direction change, comm stop, keypad stop if enabled.
// - Releasing jog decelerates using the jog deceleration time.
// - Ramp hold input freezes the ramp; release resumes from there.
// - Functions 8 and 9 form a two-bit accel/decel time selector.
// - External fault stops, is recorded, holds until restored and reset.
// - Gate block cuts output at once, coasts, and is shown.
// - Output stop cuts output, then restarts to set frequency on release.
// - Auto-ramp cancel works in modes 1-4; active selects linear ramps.
// - Analog reference input forces the analog frequency source.
// - Forced stop ramps the motor down by the stop method setting.
// - Up/down step once per press, then repeat at the set rate.
// - Up/down command clears when stopped at zero frequency.
// - PID disable input turns PID control off.
// - Counter clear input holds the event counter at zero.
// - Fourth input with code 23 increments the counter per press.
// - Codes 24 and 25 jog forward and reverse, external source only.
// - Jog in torque mode switches to speed mode until it ends.
//
// The implementer's own choices: the APB slave port and the register addresses.
`default_nettype none
module input_dispatch
  import dispatch_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Terminals and drive status.
  input wire logic [4:0] di_level,
  input wire logic drive_stopped,
  input wire logic freq_at_zero,
  input wire logic fault_event,
  input wire logic fault_cause,
  // Drive control outputs.
  output logic [3:0] speed_step,
  output logic fault_latched,
  output logic jog_run,
  output logic jog_reverse,
  output logic jog_decel,
  output logic speed_mode_force,
  output logic ramp_hold,
  output logic [1:0] accel_sel,
  output logic external_fault_trip,
  output logic gate_block,
  output logic output_cut,
  output logic linear_ramp,
  output logic freq_src_analog,
  output logic stop_cmd,
  output logic stop_coast,
  output logic pid_disable,
  output logic [15:0] updown_freq,
  output logic [15:0] event_count,
  output logic count_reached
);

  typedef struct packed {
    logic [24:0] func_sel;
    logic run_src_ext;
    logic keypad_stop_enable;
    logic stop_method_setting;
    logic [2:0] auto_ramp_setting;
    logic torque_mode;
    logic no_retain;
    logic [15:0] updown_rate_value;
    logic [15:0] counter_target;
    logic jog_dir;
    logic [4:0] di_prev;
    logic fault;
    logic ext_fault;
    jog_e jog;
    logic [15:0] updown;
    logic [15:0] rate_cnt;
    logic [15:0] count;
    logic [31:0] rdata;
    logic err;
    logic [3:0] step;
    logic hold;
    logic [1:0] acc;
    logic gb;
    logic cut;
    logic lin;
    logic analog;
    logic stop;
    logic pid_off;
  } state_s;

  state_s st_ff;
  state_s nxt_st;

  // True when any terminal assigned the code is at its active level.
  function automatic logic fn_on(input logic [24:0] sel, input logic [4:0] lvl, input logic [4:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_DI; i++) begin
      if (sel[i*FUNC_W +: FUNC_W] == code && lvl[i]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // Decoded APB strobes and terminal levels, now and one cycle back.
  logic wr_en;
  logic rd_setup;
  logic reset_req;
  logic ext_in;
  logic jog_fwd_in;
  logic jog_rev_in;
  logic jog_any;
  logic jog_stop_req;
  logic up_edge;
  logic dn_edge;
  logic up_on;
  logic dn_on;
  logic cnt_edge;
  logic addr_ok;

  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign addr_ok = (paddr == OFF_FUNC_SEL) || (paddr == OFF_CTRL) || (paddr == OFF_STATUS) ||
                   (paddr == OFF_COUNT) || (paddr == OFF_UPDOWN) || (paddr == OFF_CMD) ||
                   (paddr == OFF_TARGET);
  // Responses are zero-wait: read data is captured in the setup cycle.
  assign pready = psel && penable;
  assign pslverr = psel && penable && st_ff.err;
  assign prdata = st_ff.rdata;

  // Terminal decode shared by the sequencing below.
  always_comb begin
    reset_req = (fn_on(st_ff.func_sel, di_level, FN_RESET) && !fn_on(st_ff.func_sel, st_ff.di_prev, FN_RESET)) ||
                (wr_en && paddr == OFF_CMD && pwdata[CMD_KEY_RESET]);
    ext_in = fn_on(st_ff.func_sel, di_level, FN_EXT_FAULT);
    jog_fwd_in = st_ff.run_src_ext && fn_on(st_ff.func_sel, di_level, FN_JOG_FWD);
    jog_rev_in = st_ff.run_src_ext && fn_on(st_ff.func_sel, di_level, FN_JOG_REV);
    jog_any = jog_fwd_in || jog_rev_in || (st_ff.run_src_ext && fn_on(st_ff.func_sel, di_level, FN_JOG));
    jog_stop_req = (wr_en && paddr == OFF_CMD && pwdata[CMD_COMM_STOP]) ||
                   (wr_en && paddr == OFF_CMD && pwdata[CMD_KEY_STOP] && st_ff.keypad_stop_enable);
    up_on = fn_on(st_ff.func_sel, di_level, FN_UP);
    dn_on = fn_on(st_ff.func_sel, di_level, FN_DOWN);
    up_edge = up_on && !fn_on(st_ff.func_sel, st_ff.di_prev, FN_UP);
    dn_edge = dn_on && !fn_on(st_ff.func_sel, st_ff.di_prev, FN_DOWN);
    cnt_edge = st_ff.func_sel[FOURTH_DI*FUNC_W +: FUNC_W] == FN_CNT_INPUT &&
               di_level[FOURTH_DI] && !st_ff.di_prev[FOURTH_DI];
  end

  // Next-state logic for the whole block.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.di_prev = di_level;
    // Register writes take effect at the access edge.
    if (wr_en) begin
      case (paddr)
        OFF_FUNC_SEL: nxt_st.func_sel = pwdata[24:0];
        OFF_CTRL: begin
          nxt_st.run_src_ext = pwdata[CTRL_RUN_EXT];
          nxt_st.keypad_stop_enable = pwdata[CTRL_KEY_STOP];
          nxt_st.stop_method_setting = pwdata[CTRL_STOP_COAST];
          nxt_st.auto_ramp_setting = pwdata[CTRL_AUTO_RAMP_LSB +: 3];
          nxt_st.torque_mode = pwdata[CTRL_TORQUE];
          nxt_st.no_retain = pwdata[CTRL_NO_RETAIN];
          nxt_st.updown_rate_value = pwdata[CTRL_RATE_LSB +: 16];
        end
        OFF_CMD: begin
          if (pwdata[CMD_JOG_DIR]) begin
            nxt_st.jog_dir = !st_ff.jog_dir;
          end
        end
        OFF_TARGET: nxt_st.counter_target = pwdata[15:0];
        default: ;
      endcase
    end
    // Read data and error are prepared in the setup cycle.
    if (rd_setup) begin
      nxt_st.err = !addr_ok;
      case (paddr)
        OFF_FUNC_SEL: nxt_st.rdata = {7'h00, st_ff.func_sel};
        OFF_CTRL: nxt_st.rdata = {8'h00, st_ff.updown_rate_value, st_ff.no_retain, st_ff.torque_mode,
                                  st_ff.auto_ramp_setting, st_ff.stop_method_setting,
                                  st_ff.keypad_stop_enable, st_ff.run_src_ext};
        OFF_STATUS: nxt_st.rdata = {19'h00000, st_ff.step, st_ff.jog_dir, st_ff.jog, st_ff.pid_off,
                                    st_ff.analog, st_ff.cut, st_ff.gb, st_ff.ext_fault, st_ff.fault};
        OFF_COUNT: nxt_st.rdata = {16'h0000, st_ff.count};
        OFF_UPDOWN: nxt_st.rdata = {16'h0000, st_ff.updown};
        OFF_TARGET: nxt_st.rdata = {16'h0000, st_ff.counter_target};
        default: nxt_st.rdata = 32'h00000000;
      endcase
    end
    // Static decode, registered one cycle after the terminal level.
    nxt_st.step = {fn_on(st_ff.func_sel, di_level, FN_STEP4), fn_on(st_ff.func_sel, di_level, FN_STEP3),
                   fn_on(st_ff.func_sel, di_level, FN_STEP2), fn_on(st_ff.func_sel, di_level, FN_STEP1)};
    nxt_st.hold = fn_on(st_ff.func_sel, di_level, FN_RAMP_HOLD);
    nxt_st.acc = {fn_on(st_ff.func_sel, di_level, FN_ACC_SEL1), fn_on(st_ff.func_sel, di_level, FN_ACC_SEL0)};
    nxt_st.gb = fn_on(st_ff.func_sel, di_level, FN_GATE_BLOCK);
    nxt_st.cut = nxt_st.gb || fn_on(st_ff.func_sel, di_level, FN_OUT_STOP);
    nxt_st.lin = fn_on(st_ff.func_sel, di_level, FN_AUTO_CANCEL) && st_ff.auto_ramp_setting >= AUTO_RAMP_MIN &&
                 st_ff.auto_ramp_setting <= AUTO_RAMP_MAX;
    nxt_st.analog = fn_on(st_ff.func_sel, di_level, FN_ANALOG_REF);
    nxt_st.pid_off = fn_on(st_ff.func_sel, di_level, FN_PID_OFF);
    // A stop follows a live or latched external fault or the forced stop terminal.
    nxt_st.stop = st_ff.ext_fault || ext_in || fn_on(st_ff.func_sel, di_level, FN_FORCE_STOP);
    // Faults: the set wins over a reset in the same cycle.
    if (reset_req && !fault_cause && !ext_in) begin
      nxt_st.fault = 1'b0;
      nxt_st.ext_fault = 1'b0;
    end
    if (ext_in) begin
      nxt_st.ext_fault = 1'b1;
      nxt_st.fault = 1'b1;
    end
    if (fault_event) begin
      nxt_st.fault = 1'b1;
    end
    // Jog sequencer.
    case (st_ff.jog)
      JOG_IDLE: begin
        if (jog_any && !st_ff.fault) begin
          nxt_st.jog = JOG_WAIT;
        end
      end
      JOG_WAIT: begin
        if (!jog_any) begin
          nxt_st.jog = JOG_IDLE;
        end else if (drive_stopped) begin
          nxt_st.jog = JOG_RUN;
        end
      end
      JOG_RUN: begin
        if (!jog_any || jog_stop_req || st_ff.fault) begin
          nxt_st.jog = JOG_DECEL;
        end
        if (jog_fwd_in) begin
          nxt_st.jog_dir = 1'b0;
        end else if (jog_rev_in) begin
          nxt_st.jog_dir = 1'b1;
        end
      end
      JOG_DECEL: begin
        if (drive_stopped) begin
          nxt_st.jog = JOG_IDLE;
        end
      end
      default: nxt_st.jog = JOG_IDLE;
    endcase
    if (st_ff.jog == JOG_IDLE && jog_any) begin
      nxt_st.jog_dir = jog_rev_in ? 1'b1 : (jog_fwd_in ? 1'b0 : st_ff.jog_dir);
    end
    // Up/down stepping: one step per edge, then repeats while held.
    if (up_edge || dn_edge) begin
      nxt_st.rate_cnt = st_ff.updown_rate_value;
    end else if (up_on || dn_on) begin
      nxt_st.rate_cnt = (st_ff.rate_cnt == 16'h0000) ? st_ff.updown_rate_value : st_ff.rate_cnt - 16'h0001;
    end
    if ((up_edge || (up_on && st_ff.rate_cnt == 16'h0000)) && !dn_on && st_ff.updown != UPDOWN_MAX) begin
      nxt_st.updown = st_ff.updown + 16'h0001;
    end else if ((dn_edge || (dn_on && st_ff.rate_cnt == 16'h0000)) && !up_on && st_ff.updown != 16'h0000) begin
      nxt_st.updown = st_ff.updown - 16'h0001;
    end
    if (drive_stopped && (freq_at_zero || st_ff.no_retain)) begin
      nxt_st.updown = 16'h0000;
    end
    // Event counter: clear input wins while held.
    if (fn_on(st_ff.func_sel, di_level, FN_CNT_CLEAR)) begin
      nxt_st.count = 16'h0000;
    end else if (cnt_edge) begin
      nxt_st.count = st_ff.count + 16'h0001;
    end
  end

  // Single state register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '{func_sel: RST_FUNC_SEL, updown_rate_value: RST_UPDOWN_RATE,
                 counter_target: RST_TARGET, jog: JOG_IDLE, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs, all from the state register.
  assign speed_step = st_ff.step;
  assign fault_latched = st_ff.fault;
  assign jog_run = st_ff.jog == JOG_RUN;
  assign jog_reverse = st_ff.jog_dir;
  assign jog_decel = st_ff.jog == JOG_DECEL;
  assign speed_mode_force = st_ff.torque_mode && (st_ff.jog != JOG_IDLE);
  assign ramp_hold = st_ff.hold;
  assign accel_sel = st_ff.acc;
  assign external_fault_trip = st_ff.ext_fault;
  assign gate_block = st_ff.gb;
  assign output_cut = st_ff.cut;
  assign linear_ramp = st_ff.lin;
  assign freq_src_analog = st_ff.analog;
  assign stop_cmd = st_ff.stop;
  assign stop_coast = st_ff.stop_method_setting;
  assign pid_disable = st_ff.pid_off;
  assign updown_freq = st_ff.updown;
  assign event_count = st_ff.count;
  assign count_reached = st_ff.count >= st_ff.counter_target;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_JOG_NEEDS_STOP: assert property (st_ff.jog == JOG_WAIT && !drive_stopped |=> !jog_run)
    else $error("Jog ran before the drive stopped.");
  AST_JOG_EXT_ONLY: assert property (!st_ff.run_src_ext && st_ff.jog == JOG_IDLE |=> st_ff.jog == JOG_IDLE)
    else $error("Jog accepted without external run source.");
  AST_JOG_RELEASE: assert property (jog_run && !jog_any |=> jog_decel)
    else $error("Jog release did not decelerate.");
  AST_EXT_FAULT: assert property (ext_in |=> external_fault_trip && fault_latched ##1 stop_cmd)
    else $error("External fault not recorded.");
  AST_FAULT_HOLD: assert property (fault_latched && !reset_req |=> fault_latched)
    else $error("Fault cleared without reset.");
  AST_GATE_CUT: assert property (gate_block |-> output_cut)
    else $error("Gate block without output cut.");
  AST_TORQUE_JOG: assert property (st_ff.torque_mode && $rose(jog_run) |-> speed_mode_force)
    else $error("Jog in torque mode kept torque control.");
  AST_UP_STEP: assert property (up_edge && !dn_on && !drive_stopped && updown_freq < 16'h00ff
                                |=> updown_freq == $past(updown_freq) + 16'h0001)
    else $error("Up edge did not step once.");
  AST_CNT_CLEAR: assert property (fn_on(st_ff.func_sel, di_level, FN_CNT_CLEAR) |=> event_count == 16'h0000)
    else $error("Counter not held at zero.");
  AST_UPDOWN_ZERO: assert property (drive_stopped && freq_at_zero |=> updown_freq == 16'h0000)
    else $error("Up/down command not cleared at stop.");
  COV_JOG: cover property (jog_run ##[1:20] jog_decel);
  COV_FAULT_RESET: cover property (fault_latched ##[1:20] !fault_latched);
  COV_COUNT: cover property (cnt_edge ##1 event_count == 16'h0001);

endmodule
`default_nettype wire

// ===== common/dispatch_pkg.sv
// Purpose: Shared constants for the drive input function dispatcher.
// Assumes: 32-bit APB, one aligned word per register.
// Notes: Function codes are those that a terminal may be assigned.
`default_nettype none
package dispatch_pkg;
  localparam int NUM_DI = 5;
  localparam int FUNC_W = 5;
  // Register byte offsets.
  localparam logic [7:0] OFF_FUNC_SEL = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_COUNT = 8'h0c;
  localparam logic [7:0] OFF_UPDOWN = 8'h10;
  localparam logic [7:0] OFF_CMD = 8'h14;
  localparam logic [7:0] OFF_TARGET = 8'h18;
  // Control register fields.
  localparam int CTRL_RUN_EXT = 0;
  localparam int CTRL_KEY_STOP = 1;
  localparam int CTRL_STOP_COAST = 2;
  localparam int CTRL_AUTO_RAMP_LSB = 3;
  localparam int CTRL_TORQUE = 6;
  localparam int CTRL_NO_RETAIN = 7;
  localparam int CTRL_RATE_LSB = 8;
  // Command register bits, write-one pulses.
  localparam int CMD_KEY_STOP = 0;
  localparam int CMD_COMM_STOP = 1;
  localparam int CMD_KEY_RESET = 2;
  localparam int CMD_JOG_DIR = 3;
  // Reset values and the up/down saturation limit.
  localparam logic [24:0] RST_FUNC_SEL = 25'h0310400;
  localparam logic [15:0] RST_UPDOWN_RATE = 16'h0010;
  localparam logic [15:0] RST_TARGET = 16'h0000;
  localparam logic [15:0] UPDOWN_MAX = 16'hffff;
  // Auto-ramp modes in which the cancel input is honoured.
  localparam logic [2:0] AUTO_RAMP_MIN = 3'h1;
  localparam logic [2:0] AUTO_RAMP_MAX = 3'h4;
  // Terminal function codes and the fourth terminal's index.
  localparam logic [4:0] FN_STEP1 = 5'h01;
  localparam logic [4:0] FN_STEP2 = 5'h02;
  localparam logic [4:0] FN_STEP3 = 5'h03;
  localparam logic [4:0] FN_STEP4 = 5'h04;
  localparam logic [4:0] FN_RESET = 5'h05;
  localparam logic [4:0] FN_JOG = 5'h06;
  localparam logic [4:0] FN_RAMP_HOLD = 5'h07;
  localparam logic [4:0] FN_ACC_SEL0 = 5'h08;
  localparam logic [4:0] FN_ACC_SEL1 = 5'h09;
  localparam logic [4:0] FN_EXT_FAULT = 5'h0a;
  localparam logic [4:0] FN_GATE_BLOCK = 5'h0b;
  localparam logic [4:0] FN_OUT_STOP = 5'h0c;
  localparam logic [4:0] FN_AUTO_CANCEL = 5'h0d;
  localparam logic [4:0] FN_ANALOG_REF = 5'h0f;
  localparam logic [4:0] FN_FORCE_STOP = 5'h12;
  localparam logic [4:0] FN_UP = 5'h13;
  localparam logic [4:0] FN_DOWN = 5'h14;
  localparam logic [4:0] FN_PID_OFF = 5'h15;
  localparam logic [4:0] FN_CNT_CLEAR = 5'h16;
  localparam logic [4:0] FN_CNT_INPUT = 5'h17;
  localparam logic [4:0] FN_JOG_FWD = 5'h18;
  localparam logic [4:0] FN_JOG_REV = 5'h19;
  localparam int FOURTH_DI = 3;
  // Jog sequencer states.
  typedef enum logic [1:0] {
    JOG_IDLE = 2'b00,
    JOG_WAIT = 2'b01,
    JOG_RUN = 2'b10,
    JOG_DECEL = 2'b11
  } jog_e;
endpackage
`default_nettype wire

// ===== test/switch_model.sv
// Purpose: Model of the contacts and drive status lines that feed the dispatcher.
// Assumes: Contact bounce has already settled before a level is requested.
// Notes: stat bit 0 stopped, bit 1 zero frequency, bit 2 fault event, bit 3 fault cause.
`default_nettype none
module switch_model (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Levels asked for by the bench.
  input wire logic [4:0] want_di,
  input wire logic [3:0] want_stat,
  // Levels presented to the dispatcher.
  output logic [4:0] di_level,
  output logic [3:0] stat
);
  timeunit 1ns;
  timeprecision 1ps;
  // Levels only change on a clock edge and then hold for whole cycles, so the
  // dispatcher never samples a contact mid-transition.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      di_level <= 5'h00;
      stat <= 4'h0;
    end else begin
      di_level <= want_di;
      stat <= want_stat;
    end
  end
endmodule
`default_nettype wire

// ===== test/testbench.sv
// Purpose: Self-checking bench for the terminal function dispatcher.
// Assumes: Zero wait state APB slave; decoded outputs settle within four cycles.
// Notes: Each test after the register test programs terminal functions, moves contacts and compares outputs.
`default_nettype none
module testbench
  import dispatch_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] want_di, di_level;
  logic [3:0] want_stat, stat, speed_step;
  logic fault_latched, jog_run, jog_reverse, jog_decel, speed_mode_force, ramp_hold;
  logic external_fault_trip, gate_block, output_cut, linear_ramp, freq_src_analog;
  logic stop_cmd, stop_coast, pid_disable, count_reached;
  logic [1:0] accel_sel;
  logic [15:0] updown_freq, event_count;
  int error_cnt, num_checks, cyc;

  switch_model sw_u (.pclk, .presetn, .want_di, .want_stat, .di_level, .stat);
  input_dispatch dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .di_level, .drive_stopped(stat[0]), .freq_at_zero(stat[1]), .fault_event(stat[2]),
    .fault_cause(stat[3]), .speed_step, .fault_latched, .jog_run, .jog_reverse, .jog_decel,
    .speed_mode_force, .ramp_hold, .accel_sel, .external_fault_trip, .gate_block, .output_cut,
    .linear_ramp, .freq_src_analog, .stop_cmd, .stop_coast, .pid_disable, .updown_freq,
    .event_count, .count_reached);

  // Free running clock at 125 MHz.
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // A hung handshake or sequence is cut short here; the whole run needs far fewer cycles.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One APB transfer; an idle cycle follows so psel is never set twice in one step.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the bench timeout ends a wait for the slave.
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Contacts are held four cycles: one for the model, one for the decode, margin.
  task automatic set_di(input logic [4:0] v);
    want_di <= v;
    tick(4);
  endtask

  function automatic logic [31:0] fsel(input logic [4:0] a, b, c, d, e);
    return {7'h00, e, d, c, b, a};
  endfunction

  // Main sequence of tests.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    want_di = 5'h00;
    want_stat = 4'h0;
    presetn = 1'b0;
    tick(20);
    presetn <= 1'b1;
    tick(1);
    apb(1'b0, OFF_FUNC_SEL, 32'h0);
    check(rd, fsel(5'h00, 5'h00, 5'h01, 5'h02, 5'h03));
    apb(1'b0, OFF_CTRL, 32'h0);
    check(rd, 32'h00001000);
    apb(1'b0, 8'h1c, 32'h0);
    check({rd[30:0], err}, 32'h00000001);
    $display("test registers done");
    apb(1'b1, OFF_FUNC_SEL, fsel(FN_STEP1, FN_STEP2, FN_STEP3, FN_STEP4, 5'h00));
    for (int i = 0; i < 16; i += 5) begin
      set_di(5'(i));
      check(32'(speed_step), 32'(i));
    end
    $display("test speed steps done");
    apb(1'b1, OFF_FUNC_SEL, fsel(FN_EXT_FAULT, FN_RESET, 5'h00, 5'h00, 5'h00));
    set_di(5'h01);
    check(32'({stop_cmd, external_fault_trip, fault_latched}), 32'h7);
    apb(1'b0, OFF_STATUS, 32'h0);
    check(rd, 32'h00000003);
    set_di(5'h03);
    set_di(5'h00);
    check(32'(fault_latched), 32'h1);
    set_di(5'h02);
    check(32'({external_fault_trip, fault_latched}), 32'h0);
    set_di(5'h00);
    want_stat <= 4'hc;
    tick(4);
    want_stat <= 4'h8;
    set_di(5'h02);
    check(32'(fault_latched), 32'h1);
    want_stat <= 4'h0;
    set_di(5'h00);
    set_di(5'h02);
    check(32'(fault_latched), 32'h0);
    set_di(5'h00);
    want_stat <= 4'h4;
    tick(4);
    check(32'(fault_latched), 32'h1);
    want_stat <= 4'h0;
    apb(1'b1, OFF_CMD, 32'h4);
    check(32'(fault_latched), 32'h0);
    $display("test faults done");
    apb(1'b1, OFF_CTRL, 32'h00001014);
    apb(1'b1, OFF_FUNC_SEL, fsel(FN_RAMP_HOLD, FN_ACC_SEL0, FN_ACC_SEL1, FN_GATE_BLOCK, FN_ANALOG_REF));
    set_di(5'h1f);
    check(32'({ramp_hold, accel_sel, gate_block, output_cut, freq_src_analog}), 32'h3f);
    set_di(5'h02);
    check(32'({ramp_hold, accel_sel, gate_block, output_cut, freq_src_analog}), 32'h08);
    apb(1'b1, OFF_FUNC_SEL, fsel(FN_OUT_STOP, FN_PID_OFF, FN_FORCE_STOP, FN_AUTO_CANCEL, 5'h00));
    set_di(5'h0f);
    check(32'({output_cut, pid_disable, stop_cmd, stop_coast, linear_ramp}), 32'h1f);
    apb(1'b1, OFF_CTRL, 32'h00001000);
    tick(3);
    check(32'({linear_ramp, stop_coast}), 32'h0);
    set_di(5'h00);
    check(32'({output_cut, pid_disable, stop_cmd}), 32'h0);
    $display("test level functions done");
    apb(1'b1, OFF_TARGET, 32'h3);
    apb(1'b1, OFF_FUNC_SEL, fsel(FN_CNT_CLEAR, 5'h00, 5'h00, FN_CNT_INPUT, 5'h00));
    for (int i = 0; i < 3; i++) begin
      set_di(5'h08);
      set_di(5'h00);
    end
    check(32'({count_reached, event_count}), 32'h10003);
    apb(1'b0, OFF_COUNT, 32'h0);
    check(rd, 32'h00000003);
    set_di(5'h09);
    check(32'(event_count), 32'h0);
    set_di(5'h00);
    set_di(5'h08);
    check(32'(event_count), 32'h1);
    apb(1'b1, OFF_FUNC_SEL, fsel(5'h00, 5'h00, FN_CNT_INPUT, 5'h00, 5'h00));
    set_di(5'h04);
    set_di(5'h00);
    check(32'(event_count), 32'h1);
    $display("test counter done");
    apb(1'b1, OFF_CTRL, 32'h00ffff00);
    apb(1'b1, OFF_FUNC_SEL, fsel(FN_UP, FN_DOWN, 5'h00, 5'h00, 5'h00));
    for (int i = 0; i < 3; i++) begin
      set_di(i == 2 ? 5'h02 : 5'h01);
      set_di(5'h00);
    end
    check(32'(updown_freq), 32'h1);
    apb(1'b0, OFF_UPDOWN, 32'h0);
    check(rd, 32'h00000001);
    apb(1'b1, OFF_CTRL, 32'h00000000);
    set_di(5'h01);
    tick(6);
    set_di(5'h00);
    check(32'(updown_freq > 16'h0004), 32'h1);
    want_stat <= 4'h1;
    tick(4);
    check(32'(updown_freq != 16'h0000), 32'h1);
    want_stat <= 4'h3;
    tick(4);
    check(32'(updown_freq), 32'h0);
    apb(1'b1, OFF_CTRL, 32'h00000080);
    want_stat <= 4'h0;
    set_di(5'h01);
    set_di(5'h00);
    want_stat <= 4'h1;
    tick(4);
    check(32'(updown_freq), 32'h0);
    $display("test up down done");
    apb(1'b1, OFF_CTRL, 32'h00000000);
    apb(1'b1, OFF_FUNC_SEL, fsel(FN_JOG_FWD, FN_JOG_REV, FN_JOG, 5'h00, 5'h00));
    set_di(5'h01);
    check(32'(jog_run), 32'h0);
    set_di(5'h00);
    apb(1'b1, OFF_CTRL, 32'h00000041);
    want_stat <= 4'h0;
    set_di(5'h02);
    check(32'({jog_run, speed_mode_force}), 32'h1);
    want_stat <= 4'h1;
    tick(4);
    check(32'({jog_run, jog_reverse, speed_mode_force}), 32'h7);
    want_stat <= 4'h0;
    set_di(5'h00);
    check(32'({jog_run, jog_decel}), 32'h1);
    want_stat <= 4'h1;
    tick(4);
    check(32'({jog_decel, speed_mode_force}), 32'h0);
    set_di(5'h04);
    apb(1'b1, OFF_CMD, 32'h8);
    check(32'({jog_run, jog_reverse}), 32'h2);
    apb(1'b1, OFF_CMD, 32'h1);
    check(32'(jog_run), 32'h1);
    apb(1'b1, OFF_CMD, 32'h2);
    check(32'(jog_run), 32'h0);
    set_di(5'h00);
    // Keypad stop is honoured once its enable bit is set.
    apb(1'b1, OFF_CTRL, 32'h00000043);
    set_di(5'h04);
    check(32'(jog_run), 32'h1);
    apb(1'b1, OFF_CMD, 32'h1);
    check(32'(jog_run), 32'h0);
    set_di(5'h00);
    $display("test jog done");
    print_verdict();
  end
endmodule
`default_nettype wire
